/* File: src/pcrc_defines.svh */
// register offsets, field positions, reset values and sizes for the crc generator
`ifndef PCRC_DEFINES_SVH
`define PCRC_DEFINES_SVH
`define PCRC_OFS_CTRL      5'h00
`define PCRC_OFS_TAPS      5'h04
`define PCRC_OFS_RESULT    5'h08
`define PCRC_OFS_WDATA     5'h0c
`define PCRC_OFS_POWER     5'h10
`define PCRC_ADDR_W        5
`define PCRC_LEN_LSB       0
`define PCRC_GO_BIT        4
`define PCRC_EMPTY_BIT     6
`define PCRC_FULL_BIT      7
`define PCRC_VW_LSB        8
`define PCRC_IDLE_STOP_BIT 13
`define PCRC_DEPTH_SMALL   5'h08
`define PCRC_DEPTH_LARGE   5'h10
`define PCRC_LEN_SPLIT     4'h7
`define PCRC_TAPS_RESET    16'h0000
`define PCRC_TAPS_MASK     16'hfffe
`endif

/* File: src/pcrc_pkg.sv */
// types shared by the crc generator
package pcrc_pkg;
  typedef struct packed {
    logic [4:0]  addr;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } pcrc_bus_req_type;
  typedef enum logic [0:0] {
    PCRC_STOPPED,
    PCRC_SHIFTING
  } pcrc_state_type;
endpackage

/* File: src/pcrc_top.sv */
// programmable crc generator with data fifo and avalon-mm register slave
`include "pcrc_defines.svh"

module pcrc_top
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // power save requests, from another clock domain
  input  wire logic        sleep_i,
  input  wire logic        idle_i,
  // event output
  output logic             crc_event_o
);

  pcrc_pkg::pcrc_bus_req_type req;
  pcrc_pkg::pcrc_state_type   state_reg;
  logic [15:0] fifo_reg [16];
  logic [3:0]  wr_ptr_reg;
  logic [3:0]  rd_ptr_reg;
  logic [4:0]  valid_word_count;
  logic [4:0]  count_next;
  logic [3:0]  poly_length_field;
  logic        shift_start_control;
  logic        idle_stop_bit;
  logic [15:0] crc_polynomial_taps;
  logic [15:0] crc_result_reg;
  logic [15:0] crc_write_data_reg;
  logic [3:0]  bit_cnt_reg;
  logic [4:0]  depth;
  logic        fifo_full_flag;
  logic        fifo_empty_flag;
  logic [2:0]  sleep_sync_reg;
  logic [2:0]  idle_sync_reg;
  logic        sleep_reg;
  logic        idle_reg;
  logic        frozen;
  logic        ack_reg;
  logic        wr_word;
  logic        word_done;
  logic        top_lane;
  logic        feed;
  logic        shift_now;
  logic        event_pending_reg;

  assign req.addr       = avs_address_i;
  assign req.read       = avs_read_i;
  assign req.write      = avs_write_i;
  assign req.byteenable = avs_byteenable_i;
  assign req.writedata  = avs_writedata_i;

  // three-stage synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sleep_sync_reg <= 3'h0;
      idle_sync_reg  <= 3'h0;
      sleep_reg      <= 1'b0;
      idle_reg       <= 1'b0;
    end
    else
    begin
      sleep_sync_reg <= {sleep_sync_reg[1:0], sleep_i};
      idle_sync_reg  <= {idle_sync_reg[1:0], idle_i};
      if (sleep_sync_reg[1] == sleep_sync_reg[2])
        sleep_reg <= sleep_sync_reg[2];
      if (idle_sync_reg[1] == idle_sync_reg[2])
        idle_reg <= idle_sync_reg[2];
    end
  end

  // frozen state holds the fifo, count and result; the bit counter reloads and every access, read or write, waits
  assign frozen = sleep_reg || (idle_reg && idle_stop_bit);

  // one wait cycle per access keeps the slave timing fixed; the wait stretches while frozen
  assign avs_waitrequest_o = (req.read || req.write) && (!ack_reg || frozen);

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= (req.read || req.write) && !ack_reg && !frozen;
  end

  assign depth = (poly_length_field > `PCRC_LEN_SPLIT) ?
                 `PCRC_DEPTH_SMALL : `PCRC_DEPTH_LARGE;
  assign fifo_full_flag  = (valid_word_count == depth);
  assign fifo_empty_flag = (valid_word_count == 5'h00);

  // top byte lane of the word depends on the length field
  assign top_lane = (poly_length_field > `PCRC_LEN_SPLIT) ?
                    req.byteenable[1] : req.byteenable[0];
  assign wr_word  = req.write && ack_reg && !frozen &&
                    (req.addr == `PCRC_OFS_WDATA) && top_lane;

  // shifter control
  assign shift_now = (state_reg == pcrc_pkg::PCRC_SHIFTING) && !frozen &&
                     shift_start_control && (valid_word_count != 5'h00);
  assign word_done = shift_now && (bit_cnt_reg == 4'h0);

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      state_reg <= pcrc_pkg::PCRC_STOPPED;
    else if (!frozen)
    begin
      unique case (state_reg)
        pcrc_pkg::PCRC_STOPPED:
          if (shift_start_control && valid_word_count != 5'h00)
            state_reg <= pcrc_pkg::PCRC_SHIFTING;
        pcrc_pkg::PCRC_SHIFTING:
          if (!shift_start_control || count_next == 5'h00)
            state_reg <= pcrc_pkg::PCRC_STOPPED;
      endcase
    end
  end

  // valid word count; a write while full wraps to zero without an event
  always_comb
  begin
    count_next = valid_word_count;
    if (wr_word && fifo_full_flag)
      count_next = 5'h00;
    else if (wr_word && !word_done)
      count_next = valid_word_count + 5'h01;
    else if (word_done && !wr_word)
      count_next = valid_word_count - 5'h01;
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      valid_word_count <= 5'h00;
    else
      valid_word_count <= count_next;
  end

  // fifo storage and pointers
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
    end
    else if (wr_word && fifo_full_flag)
    begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
    end
    else
    begin
      if (wr_word)
        wr_ptr_reg <= (wr_ptr_reg + 4'h1) & (depth[3:0] - 4'h1 | {depth[4], 3'h7});
      if (word_done)
        rd_ptr_reg <= (rd_ptr_reg + 4'h1) & (depth[3:0] - 4'h1 | {depth[4], 3'h7});
    end
  end

  // partial bytes gather in the staging register until the top byte lands
  always_ff @(posedge clock_i)
  begin
    if (req.write && ack_reg && !frozen && req.addr == `PCRC_OFS_WDATA)
    begin
      if (req.byteenable[0])
        crc_write_data_reg[7:0] <= req.writedata[7:0];
      if (req.byteenable[1])
        crc_write_data_reg[15:8] <= req.writedata[15:8];
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (wr_word)
      fifo_reg[wr_ptr_reg] <= {req.byteenable[1] ? req.writedata[15:8] :
                               crc_write_data_reg[15:8],
                               req.byteenable[0] ? req.writedata[7:0] :
                               crc_write_data_reg[7:0]};
  end

  // bit counter walks from the word's msb down to bit zero
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      bit_cnt_reg <= 4'h0;
    else if (!shift_now)
      bit_cnt_reg <= poly_length_field;
    else if (bit_cnt_reg == 4'h0)
      bit_cnt_reg <= poly_length_field;
    else
      bit_cnt_reg <= bit_cnt_reg - 4'h1;
  end

  // remainder register, one bit per clock
  assign feed = fifo_reg[rd_ptr_reg][bit_cnt_reg] ^
                crc_result_reg[poly_length_field];

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      crc_result_reg <= 16'h0000;
    else if (req.write && ack_reg && !frozen && req.addr == `PCRC_OFS_RESULT)
    begin
      if (req.byteenable[0])
        crc_result_reg[7:0] <= req.writedata[7:0];
      if (req.byteenable[1])
        crc_result_reg[15:8] <= req.writedata[15:8];
    end
    else if (shift_now)
    begin
      // bit zero always takes feedback; the top term is implicit in using feed
      crc_result_reg <= ({crc_result_reg[14:0], 1'b0} ^
                        ({16{feed}} & (crc_polynomial_taps | 16'h0001))) &
                        (16'hffff >> (4'hf - poly_length_field));
    end
  end

  // control and tap registers
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      poly_length_field   <= 4'h0;
      shift_start_control <= 1'b0;
      idle_stop_bit       <= 1'b0;
      crc_polynomial_taps <= `PCRC_TAPS_RESET;
    end
    else if (req.write && ack_reg && !frozen)
    begin
      if (req.addr == `PCRC_OFS_CTRL && req.byteenable[0])
      begin
        poly_length_field   <= req.writedata[`PCRC_LEN_LSB +: 4];
        shift_start_control <= req.writedata[`PCRC_GO_BIT];
      end
      if (req.addr == `PCRC_OFS_CTRL && req.byteenable[1])
        idle_stop_bit <= req.writedata[`PCRC_IDLE_STOP_BIT];
      if (req.addr == `PCRC_OFS_TAPS)
      begin
        if (req.byteenable[0])
          crc_polynomial_taps[7:0] <= 8'(req.writedata[15:0] & `PCRC_TAPS_MASK);
        if (req.byteenable[1])
          crc_polynomial_taps[15:8] <= req.writedata[15:8];
      end
    end
  end

  // event on one-to-zero count transition; a wrap from full never gives one
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      crc_event_o <= 1'b0;
    else
      crc_event_o <= (valid_word_count == 5'h01) && (count_next == 5'h00) &&
                     !(wr_word && fifo_full_flag);
  end

  // read data
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (req.read && !ack_reg)
    begin
      unique case (req.addr)
        `PCRC_OFS_CTRL:
          // unused bits read as zero so software can mask loosely
          avs_readdata_o <= {16'h0000,
                             2'h0,
                             idle_stop_bit,
                             valid_word_count,
                             fifo_full_flag,
                             fifo_empty_flag,
                             1'b0,
                             shift_start_control,
                             poly_length_field};
        `PCRC_OFS_TAPS:
          avs_readdata_o <= {16'h0000, crc_polynomial_taps};
        `PCRC_OFS_RESULT:
          avs_readdata_o <= {16'h0000, crc_result_reg};
        `PCRC_OFS_WDATA:
          avs_readdata_o <= {16'h0000, crc_write_data_reg};
        default:
          avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule

/* File: tb/pcrc_properties.sv */
// port-level assertions for the crc generator, bound to its top module
module pcrc_properties
(
  // clock and reset
  input wire logic        clock_i,
  input wire logic        reset_i,
  // register bus
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // power save and event
  input wire logic        sleep_i,
  input wire logic        idle_i,
  input wire logic        crc_event_o
);
  // a wait of one cycle is only promised well clear of any sleep or idle request
  logic [2:0] quiet_reg;
  logic [2:0] sleep_reg;
  logic       req;
  assign req = avs_read_i | avs_write_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  always_ff @(posedge clock_i or posedge reset_i)
    if (reset_i)
      quiet_reg <= 3'h0;
    else if (sleep_i || idle_i)
      quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7)
      quiet_reg <= quiet_reg + 3'h1;
  always_ff @(posedge clock_i or posedge reset_i)
    if (reset_i)
      sleep_reg <= 3'h0;
    else if (!sleep_i)
      sleep_reg <= 3'h0;
    else if (sleep_reg != 3'h7)
      sleep_reg <= sleep_reg + 3'h1;
  property p_wait_first; $rose(req) |-> avs_waitrequest_o; endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait on new access");
  property p_wait_one; $rose(req) && quiet_reg == 3'h7 |=> !avs_waitrequest_o; endproperty
  a_wait_one: assert property (p_wait_one) else $error("access not answered");
  property p_wait_idle; !req |-> !avs_waitrequest_o; endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait without access");
  property p_read_hold; !avs_read_i |=> $stable(avs_readdata_o); endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved");
  property p_event_pulse; crc_event_o |=> !crc_event_o; endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("event too long");
  property p_sleep_event; sleep_reg == 3'h7 |-> !crc_event_o; endproperty
  a_sleep_event: assert property (p_sleep_event) else $error("event while asleep");
  property p_reset_wait; $fell(reset_i) |-> !avs_waitrequest_o; endproperty
  a_reset_wait: assert property (p_reset_wait) else $error("wait after reset");
  property p_reset_event; $fell(reset_i) |-> !crc_event_o [*4]; endproperty
  a_reset_event: assert property (p_reset_event) else $error("event after reset");
endmodule
bind pcrc_top pcrc_properties u_pcrc_properties (.clock_i, .reset_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .sleep_i, .idle_i, .crc_event_o);

/* File: tb/tb.sv */
// self-checking testbench for the crc generator
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] A_CTL = 5'h00, A_TAP = 5'h04, A_RES = 5'h08, A_WD = 5'h0c;
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, slp = 1'b0, idl = 1'b0;
  logic [4:0]  addr = '0;
  logic [3:0]  be = '0;
  logic [31:0] wdata = '0, rdata;
  logic        wreq, ev;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, ev_cnt = 0, ev_at = 0;
  pcrc_top u_pcrc_top (.clock_i(clk), .reset_i(rst), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .sleep_i(slp), .idle_i(idl),
    .crc_event_o(ev));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // events are counted at the falling edge, where the pulse has settled
  always @(negedge clk)
  begin
    cyc++;
    if (ev === 1'b1)
    begin
      ev_cnt++;
      ev_at = cyc;
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  // one bus access; a spare cycle follows so reads never trail a data write
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= w;
    rd <= ~w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wrr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b = 4'h3);
    logic [31:0] x;
    acc(1'b1, a, d, b, x);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string s);
    logic [31:0] x;
    acc(1'b0, a, 32'h0, 4'hf, x);
    chk(s, e, x);
  endtask
  task automatic wev(input int e);
    int n;
    n = 0;
    while (ev_cnt == e && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    chk("event", e + 1, ev_cnt);
  endtask
  function automatic logic [15:0] crc_m(logic [15:0] r, logic [15:0] d, int n,
                                        logic [15:0] t);
    logic [15:0] m;
    logic        fb;
    m = 16'hffff >> (15 - n);
    for (int i = n; i >= 0; i--)
    begin
      fb = d[i] ^ r[n];
      r = (r << 1) & m;
      if (fb)
        r = r ^ ((t & m) | 16'h0001);
    end
    return r;
  endfunction
  task automatic s_regs();
    rdc(A_CTL, 32'h40, "ctrl");
    rdc(A_TAP, 32'h0, "taps");
    wrr(A_TAP, 32'hffff);
    rdc(A_TAP, 32'hfffe, "taps");
    wrr(5'h14, 32'hffff);
    rdc(5'h14, 32'h0, "unmapped");
  endtask
  task automatic s_fifo(input logic [3:0] len, input logic [3:0] b, input int dep);
    int e;
    e = ev_cnt;
    wrr(A_CTL, 32'h0 | len);
    if (b == 4'h3)
    begin
      wrr(A_WD, 32'h5a, 4'h1);
      rdc(A_CTL, 32'h40 | len, "staged");
    end
    repeat (dep) wrr(A_WD, 32'h1234, b);
    rdc(A_CTL, (dep << 8) | 32'h80 | len, "full");
    wrr(A_WD, 32'h1234, b);
    rdc(A_CTL, 32'h40 | len, "wrap");
    chk("wrap event", e, ev_cnt);
  endtask
  task automatic s_crc(input logic [3:0] len, input logic [15:0] t, input int n);
    logic [15:0] r, d;
    int          e, t0;
    r = 16'h0;
    e = ev_cnt;
    wrr(A_TAP, {16'h0, t});
    wrr(A_RES, 32'h0);
    wrr(A_CTL, 32'h0 | len);
    for (int k = 0; k < n; k++)
    begin
      d = (16'h9c + 16'(k) * 16'h3b5) & (16'hffff >> (15 - len));
      wrr(A_WD, {16'h0, d});
      r = crc_m(r, d, len, t);
    end
    rdc(A_CTL, (n << 8) | len, "count");
    repeat (20) @(posedge clk);
    chk("held", e, ev_cnt);
    wrr(A_CTL, 32'h10 | len);
    t0 = cyc;
    wev(e);
    chk("cycles", 1, ev_at - t0 >= n * (len + 1) && ev_at - t0 <= n * (len + 1) + 4);
    rdc(A_RES, {16'h0, r}, "result");
    rdc(A_CTL, 32'h50 | len, "empty");
  endtask
  task automatic s_pause(input logic [31:0] c, input logic s, input logic i, input logic lng);
    int e, t0;
    e = ev_cnt;
    wrr(A_CTL, c);
    wrr(A_WD, 32'h4d2c);
    t0 = cyc;
    slp <= s;
    idl <= i;
    repeat (30) @(posedge clk);
    slp <= 1'b0;
    idl <= 1'b0;
    wev(e);
    chk("paused", lng, ev_at - t0 > 25);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_regs();
    s_fifo(4'h7, 4'h1, 16);
    s_fifo(4'h8, 4'h3, 8);
    s_crc(4'hf, 16'h1020, 3);
    s_crc(4'h4, 16'h0012, 2);
    s_crc(4'h0, 16'h0000, 4);
    s_pause(32'h1f, 1'b1, 1'b0, 1'b1);
    s_pause(32'h201f, 1'b0, 1'b1, 1'b1);
    s_pause(32'h1f, 1'b0, 1'b1, 1'b0);
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule
